// ===== core/stepper_phase_sequencer.sv
/*
  Four-phase stepper sequencer: turns step/direction requests into per-phase
  on bits and per-phase current levels for one/two-phase full, half and
  mini-stepping. Assumes step_req and step_dir are synchronous to clk_sys and
  that the winding driver interprets the current levels.
*/
`timescale 1ns/1ps
`default_nettype none
module stepper_phase_sequencer
#(
  parameter int unsigned MINI_FACTOR = stepper_pkg::MINI_FACTOR_DEF
)
(
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Async reset, active low
  input wire stepper_pkg::step_mode_e mode, // Drive mode
  input wire logic step_req, // One-cycle step request
  input wire logic step_dir, // 1 forward, 0 reverse
  output logic [3:0] phase_on, // Phase enables, bit0 first phase
  output logic [stepper_pkg::LEVEL_W-1:0] level_a, // Current first phase
  output logic [stepper_pkg::LEVEL_W-1:0] level_b, // Current second phase
  output logic [stepper_pkg::LEVEL_W-1:0] level_c, // Current third phase
  output logic [stepper_pkg::LEVEL_W-1:0] level_d, // Current fourth phase
  output logic step_done // Pulse after each accepted step
);
  import stepper_pkg::*;

  localparam int unsigned FINE_MAX = 4 * MINI_FACTOR;

  logic [INDEX_W-1:0] pos;
  logic [INDEX_W-1:0] next_pos;
  logic [3:0] next_phase_on;
  logic [LEVEL_W-1:0] next_level [4];
  logic next_step_done;
  step_mode_e mode_q;

  // Half-sine sample for quarter-cycle fraction num/den, 0..LEVEL_FULL
  function automatic logic [LEVEL_W-1:0] sine_level(input int unsigned num, input int unsigned den);
    int unsigned x;
    int unsigned y;
    x = (num * 1024) / den;
    // Parabolic approximation of sin(pi/2 * x), x in 0..1024
    y = (x * (2048 - x)) / 4096;
    if (y > 255)
      y = 255;
    sine_level = y[LEVEL_W-1:0];
  endfunction

  // Wrap-aware step of a position within a cycle of given length
  function automatic logic [INDEX_W-1:0] step_pos(input logic [INDEX_W-1:0] p, input logic fwd,
                                                  input int unsigned len);
    int unsigned q;
    q = p % len;
    if (fwd)
      q = (q + 1) % len;
    else
      q = (q + len - 1) % len;
    step_pos = q[INDEX_W-1:0];
  endfunction

  // Position update and pattern decode
  always_comb
  begin
    int unsigned fine;
    int unsigned quad;
    int unsigned frac;
    logic [LEVEL_W-1:0] lv_cos;
    logic [LEVEL_W-1:0] lv_sin;
    fine = 0;
    quad = 0;
    frac = 0;
    lv_cos = LEVEL_OFF;
    lv_sin = LEVEL_OFF;
    next_pos = pos;
    next_step_done = 1'b0;
    next_phase_on = 4'h0;
    for (int i = 0; i < 4; i++)
      next_level[i] = LEVEL_OFF;
    if (step_req)
    begin
      next_step_done = 1'b1;
      case (mode)
        mode_one_phase, mode_two_phase: next_pos = step_pos(pos, step_dir, FULL_STEPS_PER_CYCLE);
        mode_half: next_pos = step_pos(pos, step_dir, HALF_STEPS_PER_CYCLE);
        mode_mini: next_pos = step_pos(pos, step_dir, FINE_MAX);
        default: next_pos = pos;
      endcase
    end
    else if (mode != mode_q)
      next_pos = 8'h00;
    case (mode)
      mode_one_phase: next_phase_on = 4'h1 << next_pos[1:0];
      mode_two_phase: next_phase_on = (4'h1 << next_pos[1:0]) | (4'h1 << 2'(next_pos[1:0] + 2'h1));
      mode_half:
      begin
        next_phase_on = 4'h1 << next_pos[2:1];
        if (next_pos[0])
          next_phase_on = next_phase_on | (4'h1 << 2'(next_pos[2:1] + 2'h1));
      end
      mode_mini:
      begin
        fine = next_pos;
        quad = fine / MINI_FACTOR;
        frac = fine % MINI_FACTOR;
        lv_cos = sine_level(MINI_FACTOR - frac, MINI_FACTOR);
        lv_sin = sine_level(frac, MINI_FACTOR);
        next_level[quad % 4] = lv_cos;
        next_level[(quad + 1) % 4] = lv_sin;
        for (int i = 0; i < 4; i++)
          next_phase_on[i] = (next_level[i] != LEVEL_OFF);
      end
      default: next_phase_on = 4'h0;
    endcase
    if (mode != mode_mini)
      for (int i = 0; i < 4; i++)
        next_level[i] = next_phase_on[i] ? LEVEL_FULL : LEVEL_OFF;
  end

  // State and output registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pos <= 8'h00;
      mode_q <= mode_one_phase;
      phase_on <= 4'h0;
      level_a <= 8'h00;
      level_b <= 8'h00;
      level_c <= 8'h00;
      level_d <= 8'h00;
      step_done <= 1'b0;
    end
    else
    begin
      pos <= next_pos;
      mode_q <= mode;
      phase_on <= next_phase_on;
      level_a <= next_level[0];
      level_b <= next_level[1];
      level_c <= next_level[2];
      level_d <= next_level[3];
      step_done <= next_step_done;
    end
  end

  // Assertions
  logic armed;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      armed <= 1'b0;
    else
      armed <= 1'b1;
  end

  property p_one_hot;
    @(posedge clk_sys) disable iff (!rstn) (armed && mode_q == mode_one_phase && $past(mode) == mode_one_phase)
      |-> $onehot(phase_on);
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("one-phase mode not one-hot");

  property p_fwd;
    @(posedge clk_sys) disable iff (!rstn) (armed && mode == mode_one_phase && mode_q == mode_one_phase
      && step_req && step_dir && phase_on == 4'h1) |=> phase_on == 4'h2;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward step from first phase wrong");

  property p_rev;
    @(posedge clk_sys) disable iff (!rstn) (armed && mode == mode_one_phase && mode_q == mode_one_phase
      && step_req && !step_dir && phase_on == 4'h1) |=> phase_on == 4'h8;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse step from first phase wrong");

  property p_no_opposite;
    @(posedge clk_sys) disable iff (!rstn) (armed && mode_q == mode_one_phase && mode == mode_one_phase
      && phase_on == 4'h1) |=> phase_on != 4'h4;
  endproperty
  a_no_opposite: assert property (p_no_opposite) else $error("jump to opposite phase");

  property p_cycle4;
    @(posedge clk_sys) disable iff (!rstn) (armed && mode == mode_one_phase && mode_q == mode_one_phase
      && step_req && step_dir) ##1 (step_req && step_dir && mode == mode_one_phase)[*3]
      |=> phase_on == $past(phase_on, 4);
  endproperty
  a_cycle4: assert property (p_cycle4) else $error("four steps did not close a cycle");

  property p_two;
    @(posedge clk_sys) disable iff (!rstn) (armed && mode_q == mode_two_phase && $past(mode) == mode_two_phase)
      |-> $countones(phase_on) == 2 && (phase_on == 4'h3 || phase_on == 4'h6 || phase_on == 4'hC || phase_on == 4'h9);
  endproperty
  a_two: assert property (p_two) else $error("two-phase pattern wrong");

  property p_half;
    @(posedge clk_sys) disable iff (!rstn) (armed && mode == mode_half && mode_q == mode_half && step_req)
      |=> $countones(phase_on) != $countones($past(phase_on));
  endproperty
  a_half: assert property (p_half) else $error("half step did not alternate");

  property p_mini_levels;
    @(posedge clk_sys) disable iff (!rstn) (armed && mode == mode_mini && mode_q == mode_mini && step_req)
      |=> ({level_a, level_b, level_c, level_d} != $past({level_a, level_b, level_c, level_d}));
  endproperty
  a_mini_levels: assert property (p_mini_levels) else $error("mini step left levels unchanged");

  property p_mini_pair;
    @(posedge clk_sys) disable iff (!rstn)
      (armed && mode_q == mode_mini)
      |-> ($countones(phase_on) >= 1 && $countones(phase_on) <= 2
        && phase_on != 4'h5 && phase_on != 4'hA);
  endproperty
  a_mini_pair: assert property (p_mini_pair) else $error("mini currents not on neighbours");

  property p_mini_frac;
    @(posedge clk_sys) disable iff (!rstn)
      (armed && mode == mode_mini && mode_q == mode_mini && step_req && step_dir
        && pos != INDEX_W'(FINE_MAX - 1))
      |=> pos == $past(pos) + 8'h01;
  endproperty
  a_mini_frac: assert property (p_mini_frac) else $error("mini step moved more than one fraction");

  property p_done;
    @(posedge clk_sys) disable iff (!rstn)
      step_req |=> step_done;
  endproperty
  a_done: assert property (p_done) else $error("accepted step not flagged");

  property p_no_done;
    @(posedge clk_sys) disable iff (!rstn)
      (armed && !step_req) |=> !step_done;
  endproperty
  a_no_done: assert property (p_no_done) else $error("step flagged without request");

  property p_restart;
    @(posedge clk_sys) disable iff (!rstn)
      (armed && mode != mode_q && !step_req)
      |=> pos == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("mode change did not restart cycle");

  property p_full_levels;
    @(posedge clk_sys) disable iff (!rstn)
      (armed && mode_q != mode_mini)
      |-> (level_a == (phase_on[0] ? LEVEL_FULL : LEVEL_OFF)
        && level_b == (phase_on[1] ? LEVEL_FULL : LEVEL_OFF)
        && level_c == (phase_on[2] ? LEVEL_FULL : LEVEL_OFF)
        && level_d == (phase_on[3] ? LEVEL_FULL : LEVEL_OFF));
  endproperty
  a_full_levels: assert property (p_full_levels) else $error("full-step levels disagree with enables");

  // Main scenarios reached
  c_fwd: cover property (@(posedge clk_sys) disable iff (!rstn) step_req && step_dir ##1 step_done);
  c_half_pair: cover property (@(posedge clk_sys) disable iff (!rstn) mode_q == mode_half && phase_on == 4'h3);
  c_mini_unequal: cover property (@(posedge clk_sys) disable iff (!rstn)
    mode_q == mode_mini && level_a != LEVEL_OFF && level_b != LEVEL_OFF && level_a != level_b);
  c_burst: cover property (@(posedge clk_sys) disable iff (!rstn) step_req [*4]);
  c_rev: cover property (@(posedge clk_sys) disable iff (!rstn) step_req && !step_dir ##1 phase_on == 4'h8);
endmodule // stepper_phase_sequencer
`default_nettype wire

// ===== common/stepper_pkg.sv
/*
  Shared constants for the stepper phase sequencer: modes, widths,
  current-level scale and mini-step defaults.
  Assumes a single 100 MHz clock domain and no software-visible registers.
*/
package stepper_pkg;
  // Drive modes
  typedef enum logic [1:0] {
    mode_one_phase,
    mode_two_phase,
    mode_half,
    mode_mini
  } step_mode_e;

  localparam int unsigned NUM_PHASES = 4;
  localparam int unsigned FULL_STEPS_PER_CYCLE = 4;
  localparam int unsigned HALF_STEPS_PER_CYCLE = 8;
  localparam int unsigned LEVEL_W = 8;
  localparam logic [7:0] LEVEL_FULL = 8'hFF;
  localparam logic [7:0] LEVEL_OFF = 8'h00;
  localparam int unsigned MINI_FACTOR_DEF = 10;
  localparam int unsigned INDEX_W = 8;
  localparam int unsigned CLK_PERIOD_NS = 10;
endpackage

// ===== bench/winding_model.sv
/*
  Winding driver stage model: watches the phase enables and flags any jump
  straight to the opposite phase. Assumes one clock shared with the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module winding_model
(
  input wire logic clk_sys, // System clock
  input wire logic [3:0] phase_on, // Phase enables from sequencer
  output var logic jump_bad // Set on an opposite-phase jump
);
  logic [3:0] last;
  logic seen = 1'b0;
  assign jump_bad = seen;
  // opposite jump watch, both ways round
  always @(posedge clk_sys)
  begin
    if ((last == 4'h1 && phase_on == 4'h4) || (last == 4'h2 && phase_on == 4'h8)
        || (last == 4'h4 && phase_on == 4'h1) || (last == 4'h8 && phase_on == 4'h2))
      seen <= 1'b1;
    last <= phase_on;
  end
endmodule // winding_model
`default_nettype wire

// ===== bench/tb_top.sv
/*
  Self-checking bench for the stepper phase sequencer.
  Assumes step requests are taken at the rising edge and answered one edge on.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import stepper_pkg::*;
  logic clk_sys, rstn, step_req, step_dir, step_done, jump_bad;
  step_mode_e mode;
  logic [3:0] phase_on;
  logic [7:0] level_a, level_b, level_c, level_d;
  int n_mismatch = 0;
  int total_checks = 0;
  stepper_phase_sequencer #(.MINI_FACTOR(10)) dut (.clk_sys(clk_sys), .rstn(rstn), .mode(mode),
    .step_req(step_req), .step_dir(step_dir), .phase_on(phase_on), .level_a(level_a),
    .level_b(level_b), .level_c(level_c), .level_d(level_d), .step_done(step_done));
  winding_model drv (.clk_sys(clk_sys), .phase_on(phase_on), .jump_bad(jump_bad));
  // Clock generation
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic step(input logic d);
    @(posedge clk_sys);
    step_req <= 1'b1;
    step_dir <= d;
    @(posedge clk_sys);
    step_req <= 1'b0;
    #1;
  endtask
  task automatic set_mode(input step_mode_e m);
    @(posedge clk_sys);
    mode <= m;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Walk a pattern table forward and wrap back to the start
  task automatic walk(input step_mode_e m, input logic [31:0] pat, input int n);
    set_mode(m);
    chk({4'h0, phase_on}, {4'h0, pat[3:0]});
    for (int i = 1; i <= n; i++)
    begin
      step(1'b1);
      chk({4'h0, phase_on}, {4'h0, pat[4*(i%n)+:4]});
    end
  endtask
  task automatic one_phase_dirs();
    set_mode(mode_one_phase);
    step(1'b1);
    chk({7'h0, step_done}, 8'h01);
    chk({4'h0, phase_on}, 8'h02);
    @(posedge clk_sys);
    #1;
    chk({7'h0, step_done}, 8'h00);
    set_mode(mode_two_phase);
    set_mode(mode_one_phase);
    step(1'b0);
    chk({4'h0, phase_on}, 8'h08);
  endtask
  task automatic mini_steps();
    set_mode(mode_mini);
    chk(level_a, 8'hFF);
    repeat (3) step(1'b1);
    chk({6'h0, level_a != 8'h00, level_b != 8'h00}, 8'h03);
    chk({7'h0, level_a != level_b}, 8'h01);
    repeat (7) step(1'b1);
    chk(level_b, 8'hFF);
    chk(level_a, 8'h00);
    chk(level_c, 8'h00);
    chk(level_d, 8'h00);
  endtask
  // Back-to-back requests, one per cycle
  task automatic burst(input logic d, input int n);
    @(posedge clk_sys);
    step_req <= 1'b1;
    step_dir <= d;
    repeat (n) @(posedge clk_sys);
    step_req <= 1'b0;
    #1;
  endtask
  task automatic burst_steps();
    set_mode(mode_one_phase);
    chk({4'h0, phase_on}, 8'h01);
    burst(1'b1, 4);
    chk({4'h0, phase_on}, 8'h01);
    chk(level_a, 8'hFF);
    chk(level_c, 8'h00);
    burst(1'b0, 2);
    chk({4'h0, phase_on}, 8'h04);
    chk(level_c, 8'hFF);
    chk(level_d, 8'h00);
    chk(level_a, 8'h00);
  endtask
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    mode = mode_one_phase;
    step_req = 1'b0;
    step_dir = 1'b1;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    walk(mode_one_phase, 32'h00008421, 4);
    one_phase_dirs();
    walk(mode_two_phase, 32'h00009C63, 4);
    walk(mode_half, 32'h98C46231, 8);
    mini_steps();
    burst_steps();
    chk({7'h0, jump_bad}, 8'h00);
    results();
  end
endmodule // tb_top
`default_nettype wire
